/* bench/system_clock_and_sleep_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module system_clock_and_sleep_control_test;
  import clock_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_req = 1'b0;
  logic deep_sleep_en = 1'b0;
  logic wake_irq = 1'b0;
  logic main_osc_in = 1'b0;
  logic [31:0] reg_rdata;
  logic [2:0] sys_src_sel;
  logic [6:0] sys_div;
  logic sys_clk_enable, cpu_clk_en, mem_clk_en, adc_clk_tick, pwm_clk_tick, pll_powerdown;
  logic [95:0] periph_clk_en;
  logic [13:0] pll_settings;
  logic main_osc_powerdown, internal_osc_powerdown, pll_ready, pll_lock_irq;
  int num_errors = 0;
  int cmp_count = 0;
  int n_adc, n_pwm, s;

  always #2.5 clk = ~clk;
  // Main oscillator at half the bus rate: one counter tick every two cycles
  always @(posedge clk) main_osc_in <= ~main_osc_in;

  system_clock_and_sleep_control i_system_clock_and_sleep_control (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req), .deep_sleep_en(deep_sleep_en),
    .wake_irq(wake_irq), .main_osc_in(main_osc_in), .sys_src_sel(sys_src_sel), .sys_div(sys_div),
    .sys_clk_enable(sys_clk_enable), .cpu_clk_en(cpu_clk_en), .mem_clk_en(mem_clk_en),
    .periph_clk_en(periph_clk_en), .adc_clk_tick(adc_clk_tick), .pwm_clk_tick(pwm_clk_tick),
    .pll_powerdown(pll_powerdown), .pll_settings(pll_settings), .main_osc_powerdown(main_osc_powerdown),
    .internal_osc_powerdown(internal_osc_powerdown), .pll_ready(pll_ready), .pll_lock_irq(pll_lock_irq)
  );

  task end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk

  function automatic logic [31:0] xlat(input logic [4:0] x);
    return {18'h0, PLL_F_BASE - {4'h0, x}, x};
  endfunction : xlat

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd

  // Bounded wait: 0 ready, 1 source on PLL, 2 processor clock back
  task wait_sig(input int which, input int lim);
    logic hit;
    for (int i = 0; i < lim; i++)
    begin
      @(posedge clk);
      #1;
      case (which)
        0: hit = pll_ready;
        1: hit = (sys_src_sel === SRC_PLL);
        default: hit = cpu_clk_en;
      endcase
      if (hit === 1'b1)
        return;
    end
    num_errors++;
    $display("wrong value wait %0d: expected 1, seen timeout", which);
    end_sim();
  endtask : wait_sig

  task sleep_pulse(input logic deep);
    @(posedge clk);
    sleep_req <= 1'b1;
    deep_sleep_en <= deep;
    @(posedge clk);
    sleep_req <= 1'b0;
  endtask : sleep_pulse

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("sys_src_sel", SRC_INT, sys_src_sel);
    chk("pll_powerdown", 1, pll_powerdown);
    chk("osc powerdown", {RST_PRIMARY[B_MAIN_OSC_DIS], 1'b0}, {main_osc_powerdown, internal_osc_powerdown});
    chk("periph low", RST_GATE0, periph_clk_en[31:0]);
    rd(OFS_PRIMARY, RST_PRIMARY, "primary");
    rd(OFS_EXTENDED, RST_EXTENDED, "extended");
    rd(OFS_SLEEP_GATE0, RST_GATE0, "sleep gate0");
    rd(OFS_DEEP_CFG, RST_DEEP_CFG, "deep cfg");
    rd(12'h200, 32'h00000000, "unmapped");
    wr(OFS_TRANSLATION, 32'hffffffff);
    rd(OFS_TRANSLATION, xlat(5'h0b), "translation");
    wr(OFS_RUN_GATE0 + 12'h004, 32'h0000000a);
    chk("periph run", 32'h0000000a, periph_clk_en[63:32]);
    wr(OFS_SLEEP_GATE0 + 12'h004, 32'h00000005);
    wr(OFS_DEEP_GATE0 + 12'h004, 32'h00000003);
    wr(OFS_IMC, 32'h00000040);
    // PLL enabled and selected in one write
    wr(OFS_PRIMARY, 32'h01c002c0);
    cyc(100);
    chk("src before ready", SRC_MAIN, sys_src_sel);
    cyc(8900);
    chk("ready early", 0, pll_ready);
    wait_sig(0, 1200);
    rd(OFS_RIS, 32'h00000040, "raw lock");
    chk("lock irq", 1, pll_lock_irq);
    wait_sig(1, 100);
    chk("sys_div", 4, sys_div);
    wr(OFS_MISC, 32'h00000040);
    chk("lock irq clear", 0, pll_lock_irq);
    wr(OFS_PRIMARY, 32'h01c002c0);
    cyc(2);
    chk("same crystal", 1, pll_ready);
    // New crystal, auto gating, modulator divide by four; PLL bypassed while it relocks
    wr(OFS_PRIMARY, 32'h09d20b00);
    cyc(1);
    chk("new crystal", 0, pll_ready);
    rd(OFS_TRANSLATION, xlat(5'h0c), "translation new");
    wait_sig(0, 12000);
    wr(OFS_PRIMARY, 32'h09d20300);
    wait_sig(1, 100);
    // Modulator only counts once the gate is open again
    cyc(6);
    n_adc = 0;
    n_pwm = 0;
    repeat (200)
    begin
      @(posedge clk);
      #1;
      n_adc += int'(adc_clk_tick === 1'b1);
      n_pwm += int'(pwm_clk_tick === 1'b1);
    end
    chk("adc ticks", 32'(ADC_MHZ), 32'(n_adc));
    chk("pwm ticks", 32'd50, 32'(n_pwm));
    sleep_pulse(1'b0);
    cyc(2);
    chk("cpu sleep", 0, {cpu_clk_en, mem_clk_en});
    chk("periph sleep", 32'h00000005, periph_clk_en[63:32]);
    chk("src sleep", {SRC_PLL, 7'h04}, {sys_src_sel, sys_div});
    @(posedge clk);
    wake_irq <= 1'b1;
    cyc(2);
    chk("cpu wake", 1, cpu_clk_en);
    @(posedge clk);
    wake_irq <= 1'b0;
    sleep_pulse(1'b1);
    cyc(30);
    chk("cpu deep", 0, cpu_clk_en);
    chk("periph deep", 32'h00000003, periph_clk_en[63:32]);
    chk("src deep", SRC_MAIN, sys_src_sel);
    chk("pll deep", {1'b1, DEEP_DIV_PRIMARY}, {pll_powerdown, sys_div});
    chk("deep osc pll", 15'h0, {main_osc_powerdown, pll_settings});
    @(posedge clk);
    wake_irq <= 1'b1;
    wait_sig(2, 12000);
    chk("src restored", {SRC_PLL, 7'h04}, {sys_src_sel, sys_div});
    chk("periph restored", 32'h0000000a, periph_clk_en[63:32]);
    chk("pll settings", xlat(5'h0c), 32'(pll_settings));
    @(posedge clk);
    wake_irq <= 1'b0;
    // Leave the PLL before powering it down
    wr(OFS_PRIMARY, 32'h09d20b00);
    for (s = 0; s < 5; s++)
    begin
      wr(OFS_EXTENDED, 32'h83802800 | (32'(s) << 4));
      cyc(20);
      chk("ext src", {s[2:0], 7'h08, 1'b1}, {sys_src_sel, sys_div, sys_clk_enable});
    end
    end_sim();
  end
endmodule : system_clock_and_sleep_control_test
`default_nettype wire

/* hdl/clock_ctrl_pkg.sv */
// Functional notes
// - After reset the system clock comes from the internal oscillator until software changes it.
// - Clock selector offers four oscillators, the PLL and internal oscillator divided by four.
// - With the extended-use bit set, extended config fields replace primary config fields.
// - Converter clock enable is divided down to an average 16 MHz, independent of configuration.
// - Modulator clock is a synchronous integer division of the system clock.
// - A crystal select change updates the internal PLL settings from a translation.
// - The crystal-to-PLL translation is readable through a read-only register.
// - PLL is powered down after reset until software enables it.
// - PLL has normal mode driving output and power-down mode driving none.
// - Relock starts only on a real crystal change or power-down to normal transition.
// - Ready time is a down counter on main oscillator rising edges, loaded with 0x1200.
// - PLL selected before ready keeps the oscillator; switch to PLL when counter expires.
// - Raw PLL lock flag is readable and a maskable lock interrupt is offered.
// - In run mode each peripheral clock follows its run gating bit.
// - Sleep stops processor and memory; peripherals use sleep or run gating per auto gate.
// - In sleep the system clock keeps its run-mode source and divider.
// - Deep sleep stops the processor; peripherals use deep-sleep or run gating per auto gate.
// - Deep sleep runs from main oscillator or selected internal one, main powered down then.
// - PLL selected as system source at deep-sleep entry is powered down and divider forced to 16 or 64.
// - Deep-sleep exit restores source and divider before stopped clocks run again.
// - Enabled interrupt wakes to run mode; sleep entered only on a code request.
package clock_ctrl_pkg;
  localparam logic [11:0] OFS_RIS = 12'h050;
  localparam logic [11:0] OFS_IMC = 12'h054;
  localparam logic [11:0] OFS_MISC = 12'h058;
  localparam logic [11:0] OFS_PRIMARY = 12'h060;
  localparam logic [11:0] OFS_TRANSLATION = 12'h064;
  localparam logic [11:0] OFS_EXTENDED = 12'h070;
  localparam logic [11:0] OFS_RUN_GATE0 = 12'h100;
  localparam logic [11:0] OFS_SLEEP_GATE0 = 12'h110;
  localparam logic [11:0] OFS_DEEP_GATE0 = 12'h120;
  localparam logic [11:0] OFS_DEEP_CFG = 12'h144;
  localparam logic [31:0] RST_PRIMARY = 32'h078e3ad1;
  localparam logic [31:0] RST_EXTENDED = 32'h07802810;
  localparam logic [31:0] RST_GATE0 = 32'h00000040;
  localparam logic [31:0] RST_GATE_OTHER = 32'h00000000;
  localparam logic [31:0] RST_DEEP_CFG = 32'h07800000;
  // Field positions
  localparam int B_MAIN_OSC_DIS = 0;
  localparam int B_INT_OSC_DIS = 1;
  localparam int B_OSCSRC_LO = 4;
  localparam int B_CRYSTAL_SELECT_LO = 6;
  localparam int B_BYPASS = 11;
  localparam int B_PWRDN = 13;
  localparam int B_PWM_DIV_LO = 17;
  localparam int B_USE_PWM_DIV = 20;
  localparam int B_USE_SYSTEM_DIVIDER = 22;
  localparam int B_SYSTEM_DIVIDER_LO = 23;
  localparam int B_AUTO_GATE = 27;
  localparam int B_USE_EXT = 31;
  localparam int B_LOCK_FLAG = 6;
  // Source select codes
  localparam logic [2:0] SRC_MAIN = 3'h0;
  localparam logic [2:0] SRC_INT = 3'h1;
  localparam logic [2:0] SRC_INT_DIV4 = 3'h2;
  localparam logic [2:0] SRC_LOW_30K = 3'h3;
  localparam logic [2:0] SRC_RTC = 3'h4;
  localparam logic [2:0] SRC_PLL = 3'h5;
  localparam logic [6:0] DEEP_DIV_PRIMARY = 7'h10;
  localparam logic [6:0] DEEP_DIV_EXTENDED = 7'h40;
  localparam logic [12:0] RELOCK_COUNT = 13'h1200;
  localparam logic [8:0] PLL_F_BASE = 9'h0c8; // Arbitrary translation base
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CLK_MHZ = 200;
  localparam int ADC_MHZ = 16;
  localparam int SWITCH_GAP_NS = 20;
  localparam int SWITCH_GAP_CYC = (SWITCH_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic [1:0] {MODE_RUN = 2'b00, MODE_DEEP = 2'b01, MODE_EXIT = 2'b11, MODE_SLEEP = 2'b10} mode_t;
  typedef enum logic [1:0] {SW_IDLE = 2'b00, SW_OFF = 2'b01, SW_ON = 2'b11} sw_state_t;
endpackage : clock_ctrl_pkg

/* hdl/system_clock_and_sleep_control.sv */
`timescale 1ns/1ps
`default_nettype none
module system_clock_and_sleep_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Processor side
  input wire logic sleep_req,
  input wire logic deep_sleep_en,
  input wire logic wake_irq,
  input wire logic main_osc_in,
  // Clock tree controls
  output logic [2:0] sys_src_sel,
  output logic [6:0] sys_div,
  output logic sys_clk_enable,
  output logic cpu_clk_en,
  output logic mem_clk_en,
  output logic [95:0] periph_clk_en,
  output logic adc_clk_tick,
  output logic pwm_clk_tick,
  output logic pll_powerdown,
  output logic [13:0] pll_settings,
  output logic main_osc_powerdown,
  output logic internal_osc_powerdown,
  output logic pll_ready,
  output logic pll_lock_irq
);
  import clock_ctrl_pkg::*;

  logic [31:0] primary_reg, primary_next, extended_reg, extended_next, deep_cfg_reg, deep_cfg_next;
  logic [95:0] run_gate_regs, run_gate_next, sleep_gate_regs, sleep_gate_next, deep_gate_regs, deep_gate_next;
  logic raw_flag_reg, raw_flag_next, mask_reg, mask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [12:0] relock_reg, relock_next;
  logic [4:0] crystal_select_seen_reg, crystal_select_seen_next;
  logic [13:0] translation_reg, translation_next;
  logic pd_seen_reg, pd_seen_next, main_osc_q_reg;
  mode_t mode_reg, mode_next;
  logic pll_at_entry_reg, pll_at_entry_next, ext_at_entry_reg, ext_at_entry_next;
  sw_state_t sw_reg, sw_next;
  logic [2:0] sel_reg, sel_next;
  logic [6:0] div_reg, div_next;
  logic [2:0] gap_reg, gap_next;
  logic en_reg, en_next;
  logic [7:0] adc_acc_reg, adc_acc_next;
  logic adc_tick_reg, adc_tick_next;
  logic [7:0] pwm_cnt_reg, pwm_cnt_next;
  logic pwm_tick_reg, pwm_tick_next;

  // Effective fields, extended config overrides primary
  logic use_ext, bypass_eff, pwrdn_eff, want_pll, auto_gate, deep_pll_off, main_osc_tick;
  logic relock_trig, lock_event, exit_done;
  logic [2:0] oscsrc_eff, run_src, deep_src, tgt_src;
  logic [5:0] system_divider_eff;
  logic [6:0] run_div, tgt_div;
  logic [4:0] crystal_select;
  logic [7:0] pwm_limit;
  assign use_ext = extended_reg[B_USE_EXT];
  assign oscsrc_eff = use_ext ? extended_reg[B_OSCSRC_LO +: 3] : {1'b0, primary_reg[B_OSCSRC_LO +: 2]};
  assign bypass_eff = use_ext ? extended_reg[B_BYPASS] : primary_reg[B_BYPASS];
  assign pwrdn_eff = use_ext ? extended_reg[B_PWRDN] : primary_reg[B_PWRDN];
  assign system_divider_eff = use_ext ? extended_reg[B_SYSTEM_DIVIDER_LO +: 6] : {2'h0, primary_reg[B_SYSTEM_DIVIDER_LO +: 4]};
  assign run_div = primary_reg[B_USE_SYSTEM_DIVIDER] ? {1'b0, system_divider_eff} + 7'h01 : 7'h01;
  assign auto_gate = primary_reg[B_AUTO_GATE];
  assign crystal_select = primary_reg[B_CRYSTAL_SELECT_LO +: 5];
  assign want_pll = !bypass_eff && !pwrdn_eff;
  // Oscillator stays selected until the ready counter expires
  assign run_src = (want_pll && pll_ready) ? SRC_PLL : oscsrc_eff;
  assign deep_src = (deep_cfg_reg[B_OSCSRC_LO +: 3] == SRC_PLL) ? SRC_MAIN : deep_cfg_reg[B_OSCSRC_LO +: 3];
  assign deep_pll_off = (mode_reg == MODE_DEEP) && pll_at_entry_reg;
  assign tgt_src = (mode_reg == MODE_DEEP) ? deep_src : run_src;
  assign tgt_div = deep_pll_off ? (ext_at_entry_reg ? DEEP_DIV_EXTENDED : DEEP_DIV_PRIMARY) : run_div;
  assign exit_done = (sw_reg == SW_IDLE) && en_reg && (sel_reg == run_src) && (div_reg == run_div)
    && (!want_pll || pll_ready);

  // Register file
  always_comb
  begin
    primary_next = primary_reg;
    extended_next = extended_reg;
    deep_cfg_next = deep_cfg_reg;
    run_gate_next = run_gate_regs;
    sleep_gate_next = sleep_gate_regs;
    deep_gate_next = deep_gate_regs;
    mask_next = mask_reg;
    raw_flag_next = raw_flag_reg;
    rdata_next = 32'h00000000;
    if (reg_wr)
    begin
      case (reg_addr)
        OFS_IMC: mask_next = reg_wdata[B_LOCK_FLAG];
        OFS_MISC: if (reg_wdata[B_LOCK_FLAG]) raw_flag_next = 1'b0;
        OFS_PRIMARY: primary_next = reg_wdata;
        OFS_EXTENDED: extended_next = reg_wdata;
        OFS_DEEP_CFG: deep_cfg_next = reg_wdata;
        OFS_RUN_GATE0: run_gate_next[31:0] = reg_wdata;
        OFS_RUN_GATE0 + 12'h004: run_gate_next[63:32] = reg_wdata;
        OFS_RUN_GATE0 + 12'h008: run_gate_next[95:64] = reg_wdata;
        OFS_SLEEP_GATE0: sleep_gate_next[31:0] = reg_wdata;
        OFS_SLEEP_GATE0 + 12'h004: sleep_gate_next[63:32] = reg_wdata;
        OFS_SLEEP_GATE0 + 12'h008: sleep_gate_next[95:64] = reg_wdata;
        OFS_DEEP_GATE0: deep_gate_next[31:0] = reg_wdata;
        OFS_DEEP_GATE0 + 12'h004: deep_gate_next[63:32] = reg_wdata;
        OFS_DEEP_GATE0 + 12'h008: deep_gate_next[95:64] = reg_wdata;
        default: ;
      endcase
    end
    // Lock event beats a same-cycle clear
    if (lock_event)
      raw_flag_next = 1'b1;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_RIS: rdata_next[B_LOCK_FLAG] = raw_flag_reg;
        OFS_IMC: rdata_next[B_LOCK_FLAG] = mask_reg;
        OFS_MISC: rdata_next[B_LOCK_FLAG] = raw_flag_reg & mask_reg;
        OFS_PRIMARY: rdata_next = primary_reg;
        OFS_TRANSLATION: rdata_next = {18'h0, translation_reg};
        OFS_EXTENDED: rdata_next = extended_reg;
        OFS_DEEP_CFG: rdata_next = deep_cfg_reg;
        OFS_RUN_GATE0: rdata_next = run_gate_regs[31:0];
        OFS_RUN_GATE0 + 12'h004: rdata_next = run_gate_regs[63:32];
        OFS_RUN_GATE0 + 12'h008: rdata_next = run_gate_regs[95:64];
        OFS_SLEEP_GATE0: rdata_next = sleep_gate_regs[31:0];
        OFS_SLEEP_GATE0 + 12'h004: rdata_next = sleep_gate_regs[63:32];
        OFS_SLEEP_GATE0 + 12'h008: rdata_next = sleep_gate_regs[95:64];
        OFS_DEEP_GATE0: rdata_next = deep_gate_regs[31:0];
        OFS_DEEP_GATE0 + 12'h004: rdata_next = deep_gate_regs[63:32];
        OFS_DEEP_GATE0 + 12'h008: rdata_next = deep_gate_regs[95:64];
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      primary_reg <= RST_PRIMARY;
      extended_reg <= RST_EXTENDED;
      deep_cfg_reg <= RST_DEEP_CFG;
      run_gate_regs <= {RST_GATE_OTHER, RST_GATE_OTHER, RST_GATE0};
      sleep_gate_regs <= {RST_GATE_OTHER, RST_GATE_OTHER, RST_GATE0};
      deep_gate_regs <= {RST_GATE_OTHER, RST_GATE_OTHER, RST_GATE0};
      mask_reg <= 1'b0;
      raw_flag_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      primary_reg <= primary_next;
      extended_reg <= extended_next;
      deep_cfg_reg <= deep_cfg_next;
      run_gate_regs <= run_gate_next;
      sleep_gate_regs <= sleep_gate_next;
      deep_gate_regs <= deep_gate_next;
      mask_reg <= mask_next;
      raw_flag_reg <= raw_flag_next;
      rdata_reg <= rdata_next;
    end
  end

  // PLL power, translation and relock timing
  assign pll_powerdown = pwrdn_eff || deep_pll_off;
  assign main_osc_tick = main_osc_in && !main_osc_q_reg;
  assign relock_trig = (crystal_select != crystal_select_seen_reg) || (pd_seen_reg && !pll_powerdown);
  assign lock_event = !relock_trig && !pll_powerdown && main_osc_tick && (relock_reg == 13'h0001);
  assign pll_ready = !pll_powerdown && (relock_reg == 13'h0000);

  always_comb
  begin
    crystal_select_seen_next = crystal_select;
    pd_seen_next = pll_powerdown;
    translation_next = translation_reg;
    relock_next = relock_reg;
    if (crystal_select != crystal_select_seen_reg)
      translation_next = {PLL_F_BASE - {4'h0, crystal_select}, crystal_select};
    if (relock_trig)
      relock_next = RELOCK_COUNT;
    else if (!pll_powerdown && main_osc_tick && relock_reg != 13'h0000)
      relock_next = relock_reg - 13'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      crystal_select_seen_reg <= 5'h00;
      pd_seen_reg <= 1'b1;
      translation_reg <= 14'h0000;
      relock_reg <= RELOCK_COUNT;
      main_osc_q_reg <= 1'b0;
    end
    else
    begin
      crystal_select_seen_reg <= crystal_select_seen_next;
      pd_seen_reg <= pd_seen_next;
      translation_reg <= translation_next;
      relock_reg <= relock_next;
      main_osc_q_reg <= main_osc_in;
    end
  end
  // PLL output is only meaningful in normal mode
  assign pll_settings = pll_powerdown ? 14'h0000 : translation_reg;
  assign pll_lock_irq = raw_flag_reg && mask_reg;

  // Power mode sequencing
  always_comb
  begin
    mode_next = mode_reg;
    pll_at_entry_next = pll_at_entry_reg;
    ext_at_entry_next = ext_at_entry_reg;
    case (mode_reg)
      MODE_RUN:
        if (sleep_req)
        begin
          mode_next = deep_sleep_en ? MODE_DEEP : MODE_SLEEP;
          pll_at_entry_next = deep_sleep_en && (sel_reg == SRC_PLL);
          ext_at_entry_next = use_ext;
        end
      MODE_SLEEP:
        if (wake_irq)
          mode_next = MODE_RUN;
      MODE_DEEP:
        if (wake_irq)
          mode_next = MODE_EXIT;
      MODE_EXIT:
        if (exit_done)
        begin
          mode_next = MODE_RUN;
          pll_at_entry_next = 1'b0;
        end
      default: mode_next = MODE_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_reg <= MODE_RUN;
      pll_at_entry_reg <= 1'b0;
      ext_at_entry_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      pll_at_entry_reg <= pll_at_entry_next;
      ext_at_entry_reg <= ext_at_entry_next;
    end
  end

  // Glitch-free switch: gate off, change select, settle, gate on
  always_comb
  begin
    sw_next = sw_reg;
    sel_next = sel_reg;
    div_next = div_reg;
    gap_next = gap_reg;
    en_next = en_reg;
    case (sw_reg)
      SW_IDLE:
        if (tgt_src != sel_reg || tgt_div != div_reg)
        begin
          sw_next = SW_OFF;
          en_next = 1'b0;
          gap_next = 3'(SWITCH_GAP_CYC);
        end
      SW_OFF:
        if (gap_reg != 3'h0)
          gap_next = gap_reg - 3'h1;
        else
        begin
          sel_next = tgt_src;
          div_next = tgt_div;
          gap_next = 3'(SWITCH_GAP_CYC);
          sw_next = SW_ON;
        end
      SW_ON:
        if (gap_reg != 3'h0)
          gap_next = gap_reg - 3'h1;
        else
        begin
          en_next = 1'b1;
          sw_next = SW_IDLE;
        end
      default: sw_next = SW_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sw_reg <= SW_IDLE;
      sel_reg <= SRC_INT;
      div_reg <= 7'h01;
      gap_reg <= 3'h0;
      en_reg <= 1'b1;
    end
    else
    begin
      sw_reg <= sw_next;
      sel_reg <= sel_next;
      div_reg <= div_next;
      gap_reg <= gap_next;
      en_reg <= en_next;
    end
  end
  assign sys_src_sel = sel_reg;
  assign sys_div = div_reg;
  assign sys_clk_enable = en_reg;

  // Gating per mode; peripherals stay on deep gating until the exit restore is done
  assign cpu_clk_en = (mode_reg == MODE_RUN);
  assign mem_clk_en = (mode_reg == MODE_RUN);
  always_comb
  begin
    case (mode_reg)
      MODE_RUN: periph_clk_en = run_gate_regs;
      MODE_SLEEP: periph_clk_en = auto_gate ? sleep_gate_regs : run_gate_regs;
      MODE_DEEP, MODE_EXIT: periph_clk_en = auto_gate ? deep_gate_regs : run_gate_regs;
      default: periph_clk_en = run_gate_regs;
    endcase
  end
  // Deep sleep on an internal source lets the main oscillator rest
  assign main_osc_powerdown = primary_reg[B_MAIN_OSC_DIS]
    || ((mode_reg == MODE_DEEP) && deep_src != SRC_MAIN && sel_reg != SRC_MAIN);
  assign internal_osc_powerdown = primary_reg[B_INT_OSC_DIS] && sel_reg != SRC_INT && sel_reg != SRC_INT_DIV4
    && !((mode_reg == MODE_DEEP) && (deep_src == SRC_INT || deep_src == SRC_INT_DIV4));

  // Converter tick: fractional accumulator averages 16 MHz, jitter of one cycle
  assign pwm_limit = primary_reg[B_USE_PWM_DIV] ? (8'h02 << primary_reg[B_PWM_DIV_LO +: 3]) - 8'h01 : 8'h00;
  always_comb
  begin
    adc_tick_next = (adc_acc_reg + 8'(ADC_MHZ)) >= 8'(CLK_MHZ);
    adc_acc_next = adc_tick_next ? adc_acc_reg + 8'(ADC_MHZ) - 8'(CLK_MHZ) : adc_acc_reg + 8'(ADC_MHZ);
    pwm_tick_next = 1'b0;
    pwm_cnt_next = pwm_cnt_reg;
    if (en_reg)
    begin
      pwm_tick_next = (pwm_cnt_reg >= pwm_limit);
      pwm_cnt_next = pwm_tick_next ? 8'h00 : pwm_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      adc_acc_reg <= 8'h00;
      adc_tick_reg <= 1'b0;
      pwm_cnt_reg <= 8'h00;
      pwm_tick_reg <= 1'b0;
    end
    else
    begin
      adc_acc_reg <= adc_acc_next;
      adc_tick_reg <= adc_tick_next;
      pwm_cnt_reg <= pwm_cnt_next;
      pwm_tick_reg <= pwm_tick_next;
    end
  end
  assign adc_clk_tick = adc_tick_reg;
  assign pwm_clk_tick = pwm_tick_reg;
  assign reg_rdata = rdata_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_select_while_gated: assert property ($changed(sel_reg) |-> !en_reg && !$past(en_reg))
    else $error("source changed while clock enabled");
  a_pll_needs_ready: assert property (sel_reg == SRC_PLL && mode_reg == MODE_RUN && en_reg |-> pll_ready)
    else $error("PLL selected before ready");
  a_relock_load: assert property ($changed(crystal_select) |=> relock_reg == RELOCK_COUNT)
    else $error("crystal change did not reload counter");
  a_relock_steady: assert property (!relock_trig && !main_osc_tick |=> relock_reg == $past(relock_reg))
    else $error("counter moved without main oscillator edge");
  a_lock_flag_set: assert property (lock_event |=> raw_flag_reg)
    else $error("lock event lost");
  a_sleep_cpu_off: assert property (mode_reg != MODE_RUN |-> !cpu_clk_en && !mem_clk_en)
    else $error("processor clocked while asleep");
  a_sleep_same_src: assert property (mode_reg == MODE_SLEEP && $past(mode_reg) == MODE_SLEEP
    && sw_reg == SW_IDLE |-> $stable(sel_reg))
    else $error("source changed in sleep");
  // Divider latched while in deep sleep must be the override value
  a_deep_pll_down: assert property (mode_reg == MODE_DEEP && pll_at_entry_reg |-> pll_powerdown
    && ($past(mode_reg) != MODE_DEEP || !$changed(div_reg)
    || div_reg == (ext_at_entry_reg ? DEEP_DIV_EXTENDED : DEEP_DIV_PRIMARY)))
    else $error("PLL not overridden in deep sleep");
  a_exit_restored: assert property (mode_reg == MODE_EXIT ##1 mode_reg == MODE_RUN
    |-> sel_reg == run_src && en_reg)
    else $error("clocks resumed before restore");
  a_run_gating: assert property (mode_reg == MODE_RUN |-> periph_clk_en == run_gate_regs)
    else $error("run gating mismatch");
  a_sleep_entry: assert property (mode_reg == MODE_RUN && !sleep_req |=> mode_reg == MODE_RUN)
    else $error("sleep without request");
  c_pll_switch: cover property (sel_reg != SRC_PLL ##1 sel_reg == SRC_PLL);
  c_deep_round: cover property (mode_reg == MODE_EXIT ##1 mode_reg == MODE_RUN);
  c_sleep_wake: cover property (mode_reg == MODE_SLEEP ##1 mode_reg == MODE_RUN);
  c_lock_irq: cover property ($rose(pll_lock_irq));
endmodule : system_clock_and_sleep_control
`default_nettype wire
